// ---- src/bore_exec.sv ----
// Execute stage for bit clear, bit set, bit test skip if clear and rotate left
//------------------------------------------------------------
// Summary of operation
//------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
`include "bore_consts.svh"
module bore_exec #(
  parameter int DEPTH = `BORE_FILE_DEPTH
) (
  input  wire logic                  clk,
  input  wire logic                  resetn,
  input  wire bore_pkg::bore_instr_t instr,
  input  wire logic                  carry_in_load,
  input  wire logic                  carry_in,
  output var bore_pkg::bore_result_t result,
  output logic                       fwrite_reg,
  output logic [6:0]                 fwaddr_reg,
  output logic [7:0]                 fwdata_reg
);
  import bore_pkg::*;

  if (DEPTH != 128)
  begin : g_depth_bad
    $error("bore_exec needs a 128 entry file");
  end

  //------------------------------------------------------------
  // Decode
  //------------------------------------------------------------
  logic [6:0] faddr;
  logic [2:0] bsel;
  logic       dest;
  logic       is_clr;
  logic       is_set;
  logic       is_tst;
  logic       is_rlf;
  logic [7:0] fval;
  logic       exec_ok;

  assign faddr  = instr.word[`BORE_FADDR_LSB +: 7];
  assign bsel   = instr.word[`BORE_BIT_LSB +: 3];
  assign dest   = instr.word[`BORE_DEST_BIT];
  assign is_clr = instr.word[13:10] == `BORE_OP_BIT_CLEAR;
  assign is_set = instr.word[13:10] == `BORE_OP_BIT_SET;
  assign is_tst = instr.word[13:10] == `BORE_OP_BIT_TEST;
  assign is_rlf = instr.word[13:8] == `BORE_OP_ROTATE_HI;

  bore_file #(
    .DEPTH (DEPTH),
    .AW    (7)
  ) u_file (
    .clk    (clk),
    .resetn (resetn),
    .raddr  (faddr),
    .rdata  (fval),
    .we     (fwrite_reg),
    .waddr  (fwaddr_reg),
    .wdata  (fwdata_reg)
  );

  //------------------------------------------------------------
  // State and datapath
  //------------------------------------------------------------
  bore_state_t state_reg;
  bore_state_t state_next;
  logic [7:0]  w_reg;
  logic [7:0]  w_next;
  logic        carry_reg;
  logic        carry_next;
  logic        skip_next;
  logic        fwrite_next;
  logic [6:0]  fwaddr_next;
  logic [7:0]  fwdata_next;
  logic [7:0]  mask;

  assign mask = 8'h01 << bsel;

  always_comb
  begin
    state_next  = state_reg;
    w_next      = w_reg;
    carry_next  = carry_reg;
    skip_next   = 1'b0;
    fwrite_next = 1'b0;
    fwaddr_next = faddr;
    fwdata_next = fval;
    exec_ok     = 1'b0;
    if (carry_in_load)
      carry_next = carry_in;
    case (state_reg)
      ST_EXEC:
      begin
        exec_ok = instr.valid;
        if (exec_ok && is_clr)
        begin
          fwrite_next = 1'b1;
          fwdata_next = fval & ~mask;
        end
        if (exec_ok && is_set)
        begin
          fwrite_next = 1'b1;
          fwdata_next = fval | mask;
        end
        if (exec_ok && is_tst && ((fval & mask) == 8'h00))
        begin
          skip_next  = 1'b1;
          state_next = ST_FLUSH;
        end
        if (exec_ok && is_rlf)
        begin
          carry_next = fval[7];
          if (dest)
          begin
            fwrite_next = 1'b1;
            fwdata_next = {fval[6:0], carry_reg};
          end
          else
            w_next = {fval[6:0], carry_reg};
        end
      end
      ST_FLUSH:
        state_next = ST_EXEC;
      default:
        state_next = ST_EXEC;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      state_reg  <= ST_EXEC;
      w_reg      <= `BORE_W_RESET;
      carry_reg  <= 1'b0;
      fwrite_reg <= 1'b0;
      fwaddr_reg <= 7'h00;
      fwdata_reg <= 8'h00;
      result     <= '0;
    end
    else
    begin
      state_reg    <= state_next;
      w_reg        <= w_next;
      carry_reg    <= carry_next;
      fwrite_reg   <= fwrite_next;
      fwaddr_reg   <= fwaddr_next;
      fwdata_reg   <= fwdata_next;
      result.w     <= w_next;
      result.carry <= carry_next;
      result.skip  <= skip_next;
      result.busy  <= state_next == ST_FLUSH;
    end
  end

  //------------------------------------------------------------
  // Checks
  //------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence tst_clear_s;
    state_reg == ST_EXEC && instr.valid && is_tst && (fval & mask) == 8'h00;
  endsequence

  clr_write_a: assert property (state_reg == ST_EXEC && instr.valid && is_clr
    |=> fwrite_reg && fwdata_reg == ($past(fval) & ~$past(mask)))
    else $error("bit clear wrote wrong value");
  set_write_a: assert property (state_reg == ST_EXEC && instr.valid && is_set
    |=> fwrite_reg && fwdata_reg == ($past(fval) | $past(mask)))
    else $error("bit set wrote wrong value");
  tst_skip_a: assert property (tst_clear_s |=> result.skip && result.busy)
    else $error("clear bit did not skip");
  skip_flush_a: assert property (tst_clear_s |=> state_reg == ST_FLUSH ##1
    state_reg == ST_EXEC && !fwrite_reg)
    else $error("skip did not flush one slot");
  rlf_carry_a: assert property (state_reg == ST_EXEC && instr.valid && is_rlf
    |=> carry_reg == $past(fval[7]))
    else $error("rotate carry wrong");
  rlf_dest_w_a: assert property (state_reg == ST_EXEC && instr.valid && is_rlf && !dest
    |=> !fwrite_reg && w_reg == {$past(fval[6:0]), $past(carry_reg)})
    else $error("rotate to W wrong");
  rlf_dest_f_a: assert property (state_reg == ST_EXEC && instr.valid && is_rlf && dest
    |=> fwrite_reg && fwdata_reg == {$past(fval[6:0]), $past(carry_reg)})
    else $error("rotate to file wrong");
  tst_noskip_a: assert property (state_reg == ST_EXEC && instr.valid && is_tst
    && (fval & mask) != 8'h00 |=> !result.skip && state_reg == ST_EXEC)
    else $error("set bit caused a skip");
  flags_kept_a: assert property (state_reg == ST_EXEC && instr.valid && (is_clr || is_set)
    && !carry_in_load |=> $stable(carry_reg))
    else $error("bit op changed carry");
endmodule
`default_nettype wire

// ---- src/bore_consts.svh ----
// Constants for the bit-operation and rotate execute block
`ifndef BORE_CONSTS_SVH
`define BORE_CONSTS_SVH
`define BORE_OP_BIT_CLEAR   4'h4
`define BORE_OP_BIT_SET     4'h5
`define BORE_OP_BIT_TEST    4'h6
`define BORE_OP_ROTATE_HI   6'h0d
`define BORE_FADDR_LSB      0
`define BORE_BIT_LSB        7
`define BORE_DEST_BIT       7
`define BORE_W_RESET        8'h00
`define BORE_FILE_DEPTH     128
`endif

// ---- src/bore_pkg.sv ----
// Types for the bit-operation and rotate execute block
`default_nettype none
package bore_pkg;
  typedef struct packed {
    logic        valid;
    logic [13:0] word;
  } bore_instr_t;

  typedef enum logic [0:0] {
    ST_EXEC = 1'b0,
    ST_FLUSH = 1'b1
  } bore_state_t;

  typedef struct packed {
    logic [7:0] w;
    logic       carry;
    logic       skip;
    logic       busy;
  } bore_result_t;
endpackage
`default_nettype wire

// ---- src/bore_file.sv ----
// Data file register array with one combinational read port and one write port
`timescale 1ns/1ps
`default_nettype none
module bore_file #(
  parameter int DEPTH = 128,
  parameter int AW    = 7
) (
  input  wire logic          clk,
  input  wire logic          resetn,
  input  wire logic [AW-1:0] raddr,
  output logic      [7:0]    rdata,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [7:0]    wdata
);
  logic [7:0] mem [DEPTH];
  logic [7:0] mem_next [DEPTH];

  if (DEPTH > (1 << AW) || DEPTH < 1)
  begin : g_depth_bad
    $error("bore_file depth does not fit address width");
  end

  assign rdata = mem[raddr];

  always_comb
  begin
    for (int i = 0; i < DEPTH; i++)
      mem_next[i] = mem[i];
    if (we)
      mem_next[waddr] = wdata;
  end

  always_ff @(posedge clk)
  begin
    for (int i = 0; i < DEPTH; i++)
      mem[i] <= resetn ? mem_next[i] : 8'h00;
  end
endmodule
`default_nettype wire

// ---- bench/tb.sv ----
// Self-checking testbench for the bit-operation and rotate execute block
`timescale 1ns/1ps
`default_nettype none
`include "bore_consts.svh"
module tb;
  import bore_pkg::*;
  logic         clk;
  logic         resetn;
  logic         carry_in_load;
  logic         carry_in;
  bore_instr_t  instr;
  bore_result_t result;
  logic         fwrite_reg;
  logic [6:0]   fwaddr_reg;
  logic [7:0]   fwdata_reg;
  logic [7:0]   fm;
  logic         c;
  int           failures;
  int           checks_done;
  int           cycles;

  bore_exec dut_u (
    .clk           (clk),
    .resetn        (resetn),
    .instr         (instr),
    .carry_in_load (carry_in_load),
    .carry_in      (carry_in),
    .result        (result),
    .fwrite_reg    (fwrite_reg),
    .fwaddr_reg    (fwaddr_reg),
    .fwdata_reg    (fwdata_reg)
  );

  //------------------------------------------------------------
  // Clock and timeout
  //------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      failures++;
      wrap_up();
    end
  end

  //------------------------------------------------------------
  // Shared tasks
  //------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic issue(input logic [13:0] wd);
    @(posedge clk);
    #1 instr = {1'b1, wd};
    @(posedge clk);
    #1 instr = '0;
  endtask

  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  //------------------------------------------------------------
  // Scenarios
  //------------------------------------------------------------
  task automatic t_bits();
    logic [2:0] bl [3];
    bl = '{3'h7, 3'h6, 3'h0};
    for (int i = 0; i < 3; i++)
    begin
      issue({`BORE_OP_BIT_SET, bl[i], 7'h7f});
      fm = fm | (8'h01 << bl[i]);
      chk({fwrite_reg, fwaddr_reg}, {1'b1, 7'h7f});
      chk(fwdata_reg, fm);
      chk(result.carry, c);
    end
    issue({`BORE_OP_BIT_SET, 3'h3, 7'h2a});
    chk({fwrite_reg, fwaddr_reg}, {1'b1, 7'h2a});
    chk(fwdata_reg, 8'h08);
    issue({`BORE_OP_BIT_CLEAR, 3'h7, 7'h7f});
    fm = 8'h41;
    chk({fwrite_reg, fwaddr_reg}, {1'b1, 7'h7f});
    chk(fwdata_reg, fm);
    chk(result.carry, c);
    $display("t_bits done");
  endtask

  task automatic t_skip();
    @(posedge clk);
    #1 instr = {1'b1, `BORE_OP_BIT_TEST, 3'h1, 7'h7f};
    @(posedge clk);
    #1 instr = {1'b1, `BORE_OP_BIT_SET, 3'h1, 7'h7f};
    chk({result.skip, result.busy, fwrite_reg}, 3'b110);
    @(posedge clk);
    #1 instr = '0;
    chk({result.skip, result.busy, fwrite_reg}, 3'b000);
    issue({`BORE_OP_BIT_TEST, 3'h0, 7'h7f});
    chk({result.skip, result.busy, fwrite_reg}, 3'b000);
    $display("t_skip done");
  endtask

  task automatic t_rot();
    @(posedge clk);
    #1 carry_in_load = 1'b1;
    carry_in = 1'b1;
    @(posedge clk);
    #1 carry_in_load = 1'b0;
    c = 1'b1;
    issue({`BORE_OP_ROTATE_HI, 1'b0, 7'h7f});
    chk(result.w, {fm[6:0], c});
    chk(result.carry, fm[7]);
    chk(fwrite_reg, 1'b0);
    c = fm[7];
    issue({`BORE_OP_ROTATE_HI, 1'b1, 7'h7f});
    chk({fwrite_reg, fwaddr_reg}, {1'b1, 7'h7f});
    chk(fwdata_reg, {fm[6:0], c});
    chk(result.carry, fm[7]);
    chk(result.w, 8'h83);
    $display("t_rot done");
  endtask

  //------------------------------------------------------------
  // Main sequence
  //------------------------------------------------------------
  initial
  begin
    resetn = 1'b0;
    carry_in_load = 1'b0;
    carry_in = 1'b0;
    instr = '0;
    failures = 0;
    checks_done = 0;
    cycles = 0;
    fm = 8'h00;
    c = 1'b0;
    repeat (2) @(posedge clk);
    #1 resetn = 1'b1;
    chk({result.w, result.carry, fwrite_reg}, 10'h000);
    t_bits();
    t_skip();
    t_rot();
    wrap_up();
  end
endmodule
`default_nettype wire
